// ---- pkg/dnc_pkg.sv ----
package dnc_pkg;

   // ************************************************************
   // Register offsets within the filter page.
   // ************************************************************
   localparam logic [7:0] OFS_REAL_OUT   = 8'h05;
   localparam logic [7:0] OFS_INPUT_SEL  = 8'h06;
   localparam logic [7:0] OFS_OSC1_LOW   = 8'h07;
   localparam logic [7:0] OFS_OSC1_HIGH  = 8'h08;
   localparam logic [7:0] OFS_OSC2_LOW   = 8'h09;
   localparam logic [7:0] OFS_OSC2_HIGH  = 8'h0A;
   localparam logic [7:0] OFS_OSC3_LOW   = 8'h0B;
   localparam logic [7:0] OFS_OSC3_HIGH  = 8'h0C;
   localparam logic [7:0] OFS_OSC_SELECT = 8'h10;
   localparam logic [7:0] OFS_SYNC_MASK  = 8'h3E;

   // ************************************************************
   // Field positions and reset values.
   // ************************************************************
   localparam int         BIT_REAL_OUT   = 0;
   localparam int         BIT_INPUT_SEL  = 0;
   localparam int         BIT_SYNC_MASK  = 5;
   localparam int         OSC_COUNT      = 3;
   localparam int         FREQ_BITS      = 16;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [1:0] RST_OSC_SEL    = 2'h0;
   localparam logic [1:0] SEL_OSC1       = 2'h0;
   localparam logic [1:0] SEL_OSC2       = 2'h1;
   localparam logic [1:0] SEL_OSC3       = 2'h2;

   // Register write or read request carried from the control port.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dnc_req_t;

   // Configuration handed to the converter datapath.
   typedef struct packed {
      logic        real_output;
      logic        use_alternate;
      logic [15:0] active_word;
      logic [1:0]  active_osc;
      logic        phase_reset;
   } dnc_cfg_t;

endpackage

// ---- hdl/dnc_config.sv ----
module dnc_config (
   // Clock and reset.
   input  wire logic              MCLK_IN,
   input  wire logic              RST_B_IN,
   // Register port.
   input  wire dnc_pkg::dnc_req_t REQ_IN,
   output logic [7:0]             RDATA_OUT,
   // System reference input, synchronous to the clock.
   input  wire logic              SYSREF_IN,
   // Converter inputs from both channels.
   input  wire logic [13:0]       OWN_ADC_IN,
   input  wire logic [13:0]       ALT_ADC_IN,
   // Datapath configuration and selected sample.
   output dnc_pkg::dnc_cfg_t      CFG_OUT,
   output logic [13:0]            SAMPLE_OUT
);

   // ************************************************************
   // Reset release.
   // ************************************************************
   // First and second stage of the reset release.
   logic rst_sync1_reg;
   logic rst_b_reg;

   // Two stages keep the release clean against the clock. The pin asserts
   // reset at once, but its release is seen only on the second edge, so no
   // register leaves reset on a level that is still settling.
   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_sync1_reg <= 1'b0;
         rst_b_reg     <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_b_reg     <= rst_sync1_reg;
      end
   end

   // ************************************************************
   // Register file.
   // ************************************************************
   logic       real_out_reg;
   logic       input_sel_reg;
   logic       sync_mask_reg;
   logic [1:0] osc_sel_reg;
   logic [7:0] word_low_reg  [dnc_pkg::OSC_COUNT];
   logic [7:0] word_high_reg [dnc_pkg::OSC_COUNT];

   // Upper bits of the single-bit registers are write-only zeros; they are
   // not stored, so a host that breaks that rule cannot upset the datapath.
   logic wr_real_out;
   logic wr_input_sel;
   logic wr_osc_sel;
   logic wr_sync_mask;

   // Write strobes, one per control register, decoded once so that each
   // register below stays a concern of its own.
   assign wr_real_out  = REQ_IN.wr && (REQ_IN.addr == dnc_pkg::OFS_REAL_OUT);
   assign wr_input_sel = REQ_IN.wr && (REQ_IN.addr == dnc_pkg::OFS_INPUT_SEL);
   assign wr_osc_sel   = REQ_IN.wr && (REQ_IN.addr == dnc_pkg::OFS_OSC_SELECT);
   assign wr_sync_mask = REQ_IN.wr && (REQ_IN.addr == dnc_pkg::OFS_SYNC_MASK);

   // Output format: complex while clear, real at twice the rate while set.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         real_out_reg <= 1'b0;
      end else if (wr_real_out) begin
         real_out_reg <= REQ_IN.wdata[dnc_pkg::BIT_REAL_OUT];
      end
   end

   // Input source: own channel while clear, alternate channel while set.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         input_sel_reg <= 1'b0;
      end else if (wr_input_sel) begin
         input_sel_reg <= REQ_IN.wdata[dnc_pkg::BIT_INPUT_SEL];
      end
   end

   // Oscillator select code. Code 11 is not defined; it is stored as written
   // and the word selection below falls back to the first oscillator.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         osc_sel_reg <= dnc_pkg::RST_OSC_SEL;
      end else if (wr_osc_sel) begin
         osc_sel_reg <= REQ_IN.wdata[1:0];
      end
   end

   // Phase sync mask. While set, reference edges leave the oscillator phase
   // alone, so no phase reset pulse reaches the datapath.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         sync_mask_reg <= 1'b0;
      end else if (wr_sync_mask) begin
         sync_mask_reg <= REQ_IN.wdata[dnc_pkg::BIT_SYNC_MASK];
      end
   end

   // One byte pair per oscillator, each pair two offsets above the last.
   // The bytes are written one at a time with no shadow copy, so the
   // datapath sees a mixed word for the cycles between the two writes;
   // hosts that retune live should select another oscillator meanwhile.
   for (genvar i = 0; i < dnc_pkg::OSC_COUNT; i++) begin : g_osc
      localparam logic [7:0] LOW_OFS  = 8'(dnc_pkg::OFS_OSC1_LOW + 2 * i);
      localparam logic [7:0] HIGH_OFS = 8'(dnc_pkg::OFS_OSC1_HIGH + 2 * i);
      always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
         if (!rst_b_reg) begin
            word_low_reg[i]  <= dnc_pkg::RST_BYTE;
            word_high_reg[i] <= dnc_pkg::RST_BYTE;
         end else if (REQ_IN.wr && REQ_IN.addr == LOW_OFS) begin
            word_low_reg[i] <= REQ_IN.wdata;
         end else if (REQ_IN.wr && REQ_IN.addr == HIGH_OFS) begin
            word_high_reg[i] <= REQ_IN.wdata;
         end
      end
   end

   // ************************************************************
   // Read back.
   // ************************************************************
   logic [7:0] rdata_next;

   // Unused bits and unmapped offsets read as zero. Decoding straight from
   // the address keeps the read path to a single register stage.
   always_comb begin
      rdata_next = 8'h00;
      case (REQ_IN.addr)
         dnc_pkg::OFS_REAL_OUT:   rdata_next = {7'h00, real_out_reg};
         dnc_pkg::OFS_INPUT_SEL:  rdata_next = {7'h00, input_sel_reg};
         dnc_pkg::OFS_OSC1_LOW:   rdata_next = word_low_reg[0];
         dnc_pkg::OFS_OSC1_HIGH:  rdata_next = word_high_reg[0];
         dnc_pkg::OFS_OSC2_LOW:   rdata_next = word_low_reg[1];
         dnc_pkg::OFS_OSC2_HIGH:  rdata_next = word_high_reg[1];
         dnc_pkg::OFS_OSC3_LOW:   rdata_next = word_low_reg[2];
         dnc_pkg::OFS_OSC3_HIGH:  rdata_next = word_high_reg[2];
         dnc_pkg::OFS_OSC_SELECT: rdata_next = {6'h00, osc_sel_reg};
         dnc_pkg::OFS_SYNC_MASK:  rdata_next = {2'h0, sync_mask_reg, 5'h00};
         default:                 rdata_next = 8'h00;
      endcase
   end

   // Read data is registered, valid the cycle after the read strobe.
   // It holds until the next read, so a slow host may sample it late.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         RDATA_OUT <= 8'h00;
      end else if (REQ_IN.rd) begin
         RDATA_OUT <= rdata_next;
      end
   end

   // ************************************************************
   // Datapath configuration.
   // ************************************************************
   logic        sysref_d_reg;
   logic        sync_rise;
   logic [15:0] word_next;

   // Select code 11 is undefined; it falls back to the first oscillator.
   always_comb begin
      case (osc_sel_reg)
         dnc_pkg::SEL_OSC2: word_next = {word_high_reg[1], word_low_reg[1]};
         dnc_pkg::SEL_OSC3: word_next = {word_high_reg[2], word_low_reg[2]};
         default:           word_next = {word_high_reg[0], word_low_reg[0]};
      endcase
   end

   // ************************************************************
   // Phase synchronisation.
   // ************************************************************

   // Last level of the reference, for rising edge detection. It resets to
   // the idle low level, so a reference already high at reset release counts as an edge.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         sysref_d_reg <= 1'b0;
      end else begin
         sysref_d_reg <= SYSREF_IN;
      end
   end

   // Only a low-to-high step counts; a reference held high does not repeat.
   assign sync_rise = SYSREF_IN && !sysref_d_reg;

   // ************************************************************
   // Converter outputs.
   // ************************************************************

   // The word drives a phase accumulator whose step is fs / 2^16 per count.
   // Registering the configuration gives the converter clean levels; the
   // cost is one more cycle from a register write to its effect.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         CFG_OUT <= '0;
      end else begin
         CFG_OUT.real_output   <= real_out_reg;
         CFG_OUT.use_alternate <= input_sel_reg;
         CFG_OUT.active_word   <= word_next;
         CFG_OUT.active_osc    <= osc_sel_reg;
         CFG_OUT.phase_reset   <= sync_rise && !sync_mask_reg;
      end
   end

   // The sample follows the source bit of the same cycle as the flag in the
   // configuration, so the two never disagree.
   always_ff @(posedge MCLK_IN or negedge rst_b_reg) begin
      if (!rst_b_reg) begin
         SAMPLE_OUT <= 14'h0000;
      end else begin
         SAMPLE_OUT <= input_sel_reg ? ALT_ADC_IN : OWN_ADC_IN;
      end
   end

endmodule // dnc_config

// ---- testbench/dnc_config_chk.sv ----
module dnc_config_chk (
   // Clock, reset and register port.
   input wire logic              MCLK_IN,
   input wire logic              RST_B_IN,
   input wire dnc_pkg::dnc_req_t REQ_IN,
   input wire logic [7:0]        RDATA_OUT,
   // Samples and configuration.
   input wire logic              SYSREF_IN,
   input wire logic [13:0]       OWN_ADC_IN,
   input wire logic [13:0]       ALT_ADC_IN,
   input wire dnc_pkg::dnc_cfg_t CFG_OUT,
   input wire logic [13:0]       SAMPLE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   // A write lands in the datapath two cycles after it is taken.
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // Mirror of the phase sync mask, taken from the writes seen on the port.
   logic mask_seen;
   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         mask_seen <= 1'b0;
      end else if (REQ_IN.wr && REQ_IN.addr == dnc_pkg::OFS_SYNC_MASK) begin
         mask_seen <= REQ_IN.wdata[dnc_pkg::BIT_SYNC_MASK];
      end
   end
   property p_word;
      REQ_IN.wr && REQ_IN.addr == dnc_pkg::OFS_OSC1_LOW && CFG_OUT.active_osc == dnc_pkg::SEL_OSC1
         |-> ##2 CFG_OUT.active_word[7:0] == $past(REQ_IN.wdata, 2);
   endproperty
   a_word: assert property (p_word) else $error("word byte not applied");
   property p_sel;
      REQ_IN.wr && REQ_IN.addr == dnc_pkg::OFS_OSC_SELECT && REQ_IN.wdata[1:0] != 2'h3
         |-> ##2 CFG_OUT.active_osc == $past(REQ_IN.wdata[1:0], 2);
   endproperty
   a_sel: assert property (p_sel) else $error("select not applied");
   property p_real;
      REQ_IN.wr && REQ_IN.addr == dnc_pkg::OFS_REAL_OUT
         |-> ##2 CFG_OUT.real_output == $past(REQ_IN.wdata[0], 2);
   endproperty
   a_real: assert property (p_real) else $error("format not applied");
   property p_insel;
      REQ_IN.wr && REQ_IN.addr == dnc_pkg::OFS_INPUT_SEL
         |-> ##2 CFG_OUT.use_alternate == $past(REQ_IN.wdata[0], 2);
   endproperty
   a_insel: assert property (p_insel) else $error("source not applied");
   property p_alt;
      CFG_OUT.use_alternate && $past(CFG_OUT.use_alternate) |-> SAMPLE_OUT == $past(ALT_ADC_IN);
   endproperty
   a_alt: assert property (p_alt) else $error("alternate sample wrong");
   // The internal reset lags the pin, so the own path is judged only later.
   property p_own;
      $past(RST_B_IN, 3) && !CFG_OUT.use_alternate && !$past(CFG_OUT.use_alternate)
         |-> SAMPLE_OUT == $past(OWN_ADC_IN);
   endproperty
   a_own: assert property (p_own) else $error("own sample wrong");
   property p_sync;
      CFG_OUT.phase_reset |-> $past(SYSREF_IN) && !$past(SYSREF_IN, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("phase reset without rising edge");
   property p_pulse;
      CFG_OUT.phase_reset |=> !CFG_OUT.phase_reset;
   endproperty
   a_pulse: assert property (p_pulse) else $error("phase reset too long");
   // An unmasked rising edge must give the pulse on the next cycle.
   property p_edge;
      $past(RST_B_IN, 3) && $rose(SYSREF_IN) && !mask_seen |=> CFG_OUT.phase_reset;
   endproperty
   a_edge: assert property (p_edge) else $error("unmasked edge missed");
endmodule // dnc_config_chk

// ---- testbench/dnc_host.sv ----
module dnc_host (
   input wire logic              clk,
   output dnc_pkg::dnc_req_t     req,
   input wire logic [7:0]        rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req = '0;
   // Callers pass zero in every unused bit of a mapped offset.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1 req = '0;
   endtask
   // Read data is taken one cycle after the strobe edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #1 req = '0;
      @(posedge clk) #1 d = rdata;
   endtask
endmodule // dnc_host

// ---- testbench/test_dnc_config.sv ----
module test_dnc_config;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, rst_b = 1'b0, sysref = 1'b0;
   logic [13:0] own_adc = 14'h1234, alt_adc = 14'h2BCD, sample;
   logic [7:0] rdata, d;
   dnc_pkg::dnc_req_t req;
   dnc_pkg::dnc_cfg_t cfg;
   int n_fail = 0, compares = 0, cyc = 0, np;
   always #25 mclk = ~mclk;
   dnc_host host_u (.clk(mclk), .req(req), .rdata(rdata));
   dnc_config dut_u (.MCLK_IN(mclk), .RST_B_IN(rst_b), .REQ_IN(req), .RDATA_OUT(rdata),
      .SYSREF_IN(sysref), .OWN_ADC_IN(own_adc), .ALT_ADC_IN(alt_adc), .CFG_OUT(cfg),
      .SAMPLE_OUT(sample));
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // A hang counts as a mismatch.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge mclk);
      for (int a = 5; a <= 12; a++) begin
         host_u.rd(8'(a), d);
         chk(18'(d), 18'h0);
      end
      host_u.rd(8'h10, d);
      chk(18'(d), 18'h0);
      host_u.rd(8'h3E, d);
      chk(18'(d), 18'h0);
      for (int a = 7; a <= 12; a++) host_u.wr(8'(a), 8'(a) ^ 8'h5A);
      for (int a = 7; a <= 12; a++) begin
         host_u.rd(8'(a), d);
         chk(18'(d), 18'(8'(a) ^ 8'h5A));
      end
      // Each select code must hand the matching word to the datapath.
      for (int s = 0; s < 3; s++) begin
         host_u.wr(8'h10, 8'(s));
         repeat (2) @(posedge mclk);
         #1 chk({cfg.active_osc, cfg.active_word},
            {2'(s), 8'(8 + 2 * s) ^ 8'h5A, 8'(7 + 2 * s) ^ 8'h5A});
      end
      // Code 11 is undefined and falls back to the first oscillator's word.
      host_u.wr(8'h10, 8'h03);
      repeat (2) @(posedge mclk);
      #1 chk({cfg.active_osc, cfg.active_word}, {2'h3, 8'h08 ^ 8'h5A, 8'h07 ^ 8'h5A});
      host_u.rd(8'h10, d);
      chk(18'(d), 18'h3);
      for (int v = 1; v >= 0; v--) begin
         host_u.wr(8'h05, 8'(v));
         host_u.wr(8'h06, 8'(v));
         repeat (2) @(posedge mclk);
         #1 chk(18'({cfg.real_output, cfg.use_alternate, sample}),
            18'({2'(v * 3), v ? alt_adc : own_adc}));
      end
      // The reference edge resets phase only while unmasked.
      for (int m = 0; m < 2; m++) begin
         host_u.wr(8'h3E, 8'(m * 32));
         np = 0;
         @(posedge mclk) #1 sysref = 1'b1;
         repeat (4) @(posedge mclk) #1 np += int'(cfg.phase_reset);
         sysref = 1'b0;
         chk(18'(np), 18'(1 - m));
      end
      host_u.rd(8'h3E, d);
      chk(18'(d), 18'h20);
      host_u.wr(8'h20, 8'hFF);
      host_u.rd(8'h20, d);
      chk(18'(d), 18'h0);
      finish_test();
   end
endmodule // test_dnc_config
bind dnc_config dnc_config_chk chk_u (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .REQ_IN(REQ_IN),
   .RDATA_OUT(RDATA_OUT), .SYSREF_IN(SYSREF_IN), .OWN_ADC_IN(OWN_ADC_IN),
   .ALT_ADC_IN(ALT_ADC_IN), .CFG_OUT(CFG_OUT), .SAMPLE_OUT(SAMPLE_OUT));
